//--- src/cprc_defines.svh
// constants for the power-down and reset controller
// Overview of operation
// - With power-down configured, a high power-down pin puts the block into its low-power state.
// - While powered down, core_in, output data and output enables are held at their last values; fuse reads still update.
// - An output that was high-impedance when power-down began stays high-impedance throughout.
// - While powered down, every pin input except the power-down pins is blocked from core_in; the fuse read inputs are not blocked.
// - While powered down, input and bidirectional pin hold latches keep each pin at its last level.
// - Power-down acts only when enabled by configuration; otherwise the pin is an ordinary pin.
// - With power-down enabled, the power-down pin is not offered to user logic as an input.
// - The macrocell of an enabled power-down pin still supplies feedback and foldback terms.
// - After power-up all registers are initialised and outputs take their buffer-polarity state.
// - One security fuse; once programmed, pattern readback is inhibited.
// - With the fuse programmed the 16-bit user signature remains readable.
// - With two power-down pins, power-down is entered when either enabled pin is high.
// - All pin transitions are ignored until the power-down pin returns low, then operation resumes.
`ifndef CPRC_DEFINES_SVH
`define CPRC_DEFINES_SVH
`define CPRC_IO_W 8
`define CPRC_SIG_W 16
`define CPRC_PAT_W 16
`define CPRC_OUT_RST 8'h00
`define CPRC_OE_RST 8'h00
`define CPRC_SIG_RST 16'h0000
`define CPRC_PAT_RST 16'h0000
`define CPRC_CLK_PERIOD_NS 10
`define CPRC_SETTLE_NS 100
`define CPRC_SETTLE_CYC ((`CPRC_SETTLE_NS + `CPRC_CLK_PERIOD_NS - 1) / `CPRC_CLK_PERIOD_NS)
`define CPRC_SETTLE_W 8
`endif

//--- src/cprc_pkg.sv
// types for the power-down and reset controller
package cprc_pkg;
    typedef enum logic [2:0] {
        CPRC_SETTLE = 3'h1,
        CPRC_RUN = 3'h2,
        CPRC_DOWN = 3'h4
    } cprc_state_t;
endpackage : cprc_pkg

//--- src/cprc_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module cprc_sync (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic pin_in,
    output logic level_out
);
    logic s1_reg, s2_reg, s3_reg, lvl_reg;
    logic s1_next, s2_next, s3_next, lvl_next;

    always_comb begin
        s1_next = pin_in;
        s2_next = s1_reg;
        s3_next = s2_reg;
        lvl_next = (s2_reg == s3_reg) ? s3_reg : lvl_reg;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            lvl_reg <= 1'b0;
        end else begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
            s3_reg <= s3_next;
            lvl_reg <= lvl_next;
        end
    end

    assign level_out = lvl_reg;
endmodule : cprc_sync

//--- src/cprc_fuse.sv
// security fuse gate on pattern readback; signature reads are not gated by the fuse
`timescale 1ns/1ps
`include "cprc_defines.svh"
module cprc_fuse (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic fuse_blown,
    input wire logic rd_pattern,
    input wire logic rd_signature,
    input wire logic [`CPRC_PAT_W-1:0] pattern_word,
    input wire logic [`CPRC_SIG_W-1:0] signature_word,
    output logic [`CPRC_PAT_W-1:0] pattern_rd_data,
    output logic pattern_rd_denied,
    output logic [`CPRC_SIG_W-1:0] signature_rd_data
);
    logic [`CPRC_PAT_W-1:0] pat_reg, pat_next;
    logic den_reg, den_next;
    logic [`CPRC_SIG_W-1:0] sig_reg, sig_next;

    always_comb begin
        pat_next = pat_reg;
        den_next = 1'b0;
        sig_next = sig_reg;
        if (rd_pattern) begin
            pat_next = fuse_blown ? `CPRC_PAT_RST : pattern_word;
            den_next = fuse_blown;
        end
        if (rd_signature) begin
            sig_next = signature_word;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pat_reg <= `CPRC_PAT_RST;
            den_reg <= 1'b0;
            sig_reg <= `CPRC_SIG_RST;
        end else begin
            pat_reg <= pat_next;
            den_reg <= den_next;
            sig_reg <= sig_next;
        end
    end

    assign pattern_rd_data = pat_reg;
    assign pattern_rd_denied = den_reg;
    assign signature_rd_data = sig_reg;

    property p_fuse_blocks;
        @(posedge clk) disable iff (sys_rst)
        (rd_pattern && fuse_blown) |=> (pattern_rd_denied && pattern_rd_data == `CPRC_PAT_RST);
    endproperty
    a_fuse_blocks: assert property (p_fuse_blocks) else $error("pattern readable with fuse blown");

    property p_sig_open;
        @(posedge clk) disable iff (sys_rst)
        rd_signature |=> (signature_rd_data == $past(signature_word));
    endproperty
    a_sig_open: assert property (p_sig_open) else $error("signature read failed");
endmodule : cprc_fuse

//--- src/cprc_ctrl.sv
// power-down hold, input blocking and power-up reset sequencing
`timescale 1ns/1ps
`include "cprc_defines.svh"
module cprc_ctrl
    import cprc_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic pd_enable,
    input wire logic powerdown_pin_a,
    input wire logic powerdown_pin_b,
    input wire logic [`CPRC_IO_W-1:0] pin_in,
    input wire logic [`CPRC_IO_W-1:0] core_out,
    input wire logic [`CPRC_IO_W-1:0] core_oe_n,
    input wire logic [`CPRC_IO_W-1:0] out_polarity,
    input wire logic fuse_blown,
    input wire logic rd_pattern,
    input wire logic rd_signature,
    input wire logic [`CPRC_PAT_W-1:0] pattern_word,
    input wire logic [`CPRC_SIG_W-1:0] signature_word,
    output logic [`CPRC_IO_W-1:0] core_in,
    output logic core_in_a_valid,
    output logic core_in_b_valid,
    output logic [`CPRC_IO_W-1:0] pin_out,
    output logic [`CPRC_IO_W-1:0] pin_oe_n,
    output logic powered_down,
    output logic core_ready,
    output logic [`CPRC_PAT_W-1:0] pattern_rd_data,
    output logic pattern_rd_denied,
    output logic [`CPRC_SIG_W-1:0] signature_rd_data
);
    logic pd_a_lvl, pd_b_lvl;
    logic [`CPRC_IO_W-1:0] pin_lvl;
    logic pd_req;

    cprc_sync u_sync_a (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin_in(powerdown_pin_a),
        .level_out(pd_a_lvl)
    );

    cprc_sync u_sync_b (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin_in(powerdown_pin_b),
        .level_out(pd_b_lvl)
    );

    genvar gi;
    generate
        for (gi = 0; gi < `CPRC_IO_W; gi++) begin : g_pin
            cprc_sync u_sync_pin (
                .clk(clk),
                .sys_rst(sys_rst),
                .pin_in(pin_in[gi]),
                .level_out(pin_lvl[gi])
            );
        end
    endgenerate

    cprc_fuse u_fuse (
        .clk(clk),
        .sys_rst(sys_rst),
        .fuse_blown(fuse_blown),
        .rd_pattern(rd_pattern),
        .rd_signature(rd_signature),
        .pattern_word(pattern_word),
        .signature_word(signature_word),
        .pattern_rd_data(pattern_rd_data),
        .pattern_rd_denied(pattern_rd_denied),
        .signature_rd_data(signature_rd_data)
    );

    assign pd_req = pd_enable && (pd_a_lvl || pd_b_lvl);

    cprc_state_t state_reg, state_next;
    logic [`CPRC_SETTLE_W-1:0] cnt_reg, cnt_next;
    logic [`CPRC_IO_W-1:0] in_reg, in_next;
    logic [`CPRC_IO_W-1:0] out_reg, out_next;
    logic [`CPRC_IO_W-1:0] oe_reg, oe_next;
    logic a_val_reg, a_val_next, b_val_reg, b_val_next;
    logic down_reg, down_next, rdy_reg, rdy_next;

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        in_next = in_reg;
        out_next = out_reg;
        oe_next = oe_reg;
        // pd pins lose user role when enabled
        a_val_next = !pd_enable;
        b_val_next = !pd_enable;
        down_next = 1'b0;
        rdy_next = 1'b0;
        case (state_reg)
            CPRC_SETTLE: begin
                out_next = out_polarity;
                oe_next = `CPRC_OE_RST;
                if (cnt_reg == `CPRC_SETTLE_W'(`CPRC_SETTLE_CYC - 1)) begin
                    state_next = CPRC_RUN;
                    rdy_next = 1'b1;
                end else begin
                    cnt_next = cnt_reg + `CPRC_SETTLE_W'(1);
                end
            end
            CPRC_RUN: begin
                rdy_next = 1'b1;
                if (pd_req) begin
                    state_next = CPRC_DOWN;
                    down_next = 1'b1;
                end else begin
                    // pd pin cells keep their output paths
                    in_next = pin_lvl;
                    out_next = core_out;
                    oe_next = core_oe_n;
                end
            end
            CPRC_DOWN: begin
                down_next = 1'b1;
                if (!pd_req) begin
                    state_next = CPRC_RUN;
                    down_next = 1'b0;
                    rdy_next = 1'b1;
                end
            end
            default: begin
                state_next = CPRC_SETTLE;
                cnt_next = '0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= CPRC_SETTLE;
            cnt_reg <= '0;
            in_reg <= '0;
            out_reg <= `CPRC_OUT_RST;
            oe_reg <= `CPRC_OE_RST;
            a_val_reg <= 1'b0;
            b_val_reg <= 1'b0;
            down_reg <= 1'b0;
            rdy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            in_reg <= in_next;
            out_reg <= out_next;
            oe_reg <= oe_next;
            a_val_reg <= a_val_next;
            b_val_reg <= b_val_next;
            down_reg <= down_next;
            rdy_reg <= rdy_next;
        end
    end

    assign core_in = in_reg;
    assign core_in_a_valid = a_val_reg;
    assign core_in_b_valid = b_val_reg;
    assign pin_out = out_reg;
    assign pin_oe_n = oe_reg;
    assign powered_down = down_reg;
    assign core_ready = rdy_reg;

    property p_enter;
        @(posedge clk) disable iff (sys_rst)
        (state_reg == CPRC_RUN && pd_req) |=> powered_down;
    endproperty
    a_enter: assert property (p_enter) else $error("no power-down entry");

    property p_hold_out;
        @(posedge clk) disable iff (sys_rst)
        (state_reg == CPRC_DOWN) |=> (pin_out == $past(pin_out));
    endproperty
    a_hold_out: assert property (p_hold_out) else $error("output changed in power-down");

    property p_hold_hiz;
        @(posedge clk) disable iff (sys_rst)
        (state_reg == CPRC_DOWN) |=> (pin_oe_n == $past(pin_oe_n));
    endproperty
    a_hold_hiz: assert property (p_hold_hiz) else $error("enable changed in power-down");

    property p_block_in;
        @(posedge clk) disable iff (sys_rst)
        (state_reg == CPRC_DOWN) |=> (core_in == $past(core_in));
    endproperty
    a_block_in: assert property (p_block_in) else $error("input passed in power-down");

    property p_disabled;
        @(posedge clk) disable iff (sys_rst)
        !pd_enable |=> (state_reg != CPRC_DOWN || $past(state_reg) == CPRC_DOWN);
    endproperty
    a_disabled: assert property (p_disabled) else $error("power-down while disabled");

    property p_no_user;
        @(posedge clk) disable iff (sys_rst)
        pd_enable |=> !core_in_a_valid && !core_in_b_valid;
    endproperty
    a_no_user: assert property (p_no_user) else $error("pd pin offered to logic");

    property p_either;
        @(posedge clk) disable iff (sys_rst)
        (state_reg == CPRC_RUN && pd_enable && (pd_a_lvl ^ pd_b_lvl)) |=> state_reg == CPRC_DOWN;
    endproperty
    a_either: assert property (p_either) else $error("single pin did not power down");

    property p_resume;
        @(posedge clk) disable iff (sys_rst)
        (state_reg == CPRC_DOWN && !pd_req) |=> (state_reg == CPRC_RUN && !powered_down);
    endproperty
    a_resume: assert property (p_resume) else $error("no resume after pin low");

    property p_settle;
        @(posedge clk) disable iff (sys_rst)
        $fell(sys_rst) |-> !core_ready [*8];
    endproperty
    a_settle: assert property (p_settle) else $error("ready before settling");

    property p_flag_state;
        @(posedge clk) disable iff (sys_rst)
        powered_down == (state_reg == CPRC_DOWN);
    endproperty
    a_flag_state: assert property (p_flag_state) else $error("hold flag disagrees with state");

    property p_settle_out;
        @(posedge clk) disable iff (sys_rst)
        (state_reg == CPRC_SETTLE) |=> (pin_out == $past(out_polarity));
    endproperty
    a_settle_out: assert property (p_settle_out) else $error("output not at buffer polarity");

    property p_settle_oe;
        @(posedge clk) disable iff (sys_rst)
        (state_reg == CPRC_SETTLE) |=> (pin_oe_n == `CPRC_OE_RST);
    endproperty
    a_settle_oe: assert property (p_settle_oe) else $error("enable wrong while settling");

    property p_settle_done;
        @(posedge clk) disable iff (sys_rst)
        (state_reg == CPRC_SETTLE && cnt_reg == `CPRC_SETTLE_W'(`CPRC_SETTLE_CYC - 1))
            |=> (state_reg == CPRC_RUN && core_ready);
    endproperty
    a_settle_done: assert property (p_settle_done) else $error("settling did not end on time");

    property p_settle_quiet;
        @(posedge clk) disable iff (sys_rst)
        (state_reg == CPRC_SETTLE) |=> !powered_down;
    endproperty
    a_settle_quiet: assert property (p_settle_quiet) else $error("power-down while settling");

    property p_run_out;
        @(posedge clk) disable iff (sys_rst)
        (state_reg == CPRC_RUN && !pd_req) |=> (pin_out == $past(core_out));
    endproperty
    a_run_out: assert property (p_run_out) else $error("output path not passed in run");

    property p_run_oe;
        @(posedge clk) disable iff (sys_rst)
        (state_reg == CPRC_RUN && !pd_req) |=> (pin_oe_n == $past(core_oe_n));
    endproperty
    a_run_oe: assert property (p_run_oe) else $error("enable path not passed in run");

    property p_run_in;
        @(posedge clk) disable iff (sys_rst)
        (state_reg == CPRC_RUN && !pd_req) |=> (core_in == $past(pin_lvl));
    endproperty
    a_run_in: assert property (p_run_in) else $error("input path not passed in run");

    property p_valid_off;
        @(posedge clk) disable iff (sys_rst)
        !pd_enable |=> (core_in_a_valid && core_in_b_valid);
    endproperty
    a_valid_off: assert property (p_valid_off) else $error("pd pin withheld while disabled");

    property p_hold_keep;
        @(posedge clk) disable iff (sys_rst)
        (state_reg == CPRC_DOWN) |=> ($stable(pin_out) && $stable(pin_oe_n));
    endproperty
    a_hold_keep: assert property (p_hold_keep) else $error("pin level moved in power-down");

    property p_ready_down;
        @(posedge clk) disable iff (sys_rst)
        (state_reg == CPRC_DOWN && pd_req) |=> !core_ready;
    endproperty
    a_ready_down: assert property (p_ready_down) else $error("ready while held");

    property p_entry_frz;
        @(posedge clk) disable iff (sys_rst)
        (state_reg == CPRC_RUN && pd_req) |=> (pin_out == $past(pin_out) && core_in == $past(core_in));
    endproperty
    a_entry_frz: assert property (p_entry_frz) else $error("state moved on power-down entry");

    property p_both;
        @(posedge clk) disable iff (sys_rst)
        (state_reg == CPRC_RUN && pd_enable && pd_a_lvl && pd_b_lvl) |=> state_reg == CPRC_DOWN;
    endproperty
    a_both: assert property (p_both) else $error("two pins did not power down");
endmodule : cprc_ctrl

//--- testbench/cprc_board.sv
// board-side model driving the power-down and input pins
`timescale 1ns/1ps
`include "cprc_defines.svh"
module cprc_board (
    input wire logic clk,
    input wire logic core_ready,
    input wire logic want_a,
    input wire logic want_b,
    input wire logic [`CPRC_IO_W-1:0] want_pins,
    output logic powerdown_pin_a,
    output logic powerdown_pin_b,
    output logic [`CPRC_IO_W-1:0] pin_in
);
    logic seen_ready;
    initial begin
        seen_ready = 1'b0;
        powerdown_pin_a = 1'b0;
        powerdown_pin_b = 1'b0;
        pin_in = '0;
    end
    // pins stay quiet until first settle ends
    always @(posedge clk) begin
        if (core_ready) begin
            seen_ready <= 1'b1;
        end
        if (core_ready || seen_ready) begin
            powerdown_pin_a <= want_a;
            powerdown_pin_b <= want_b;
            pin_in <= want_pins;
        end
    end
endmodule : cprc_board

//--- testbench/cpld_powerdown_reset_ctrl_tb.sv
// self-checking bench for the power-down and reset controller
`timescale 1ns/1ps
`include "cprc_defines.svh"
module cpld_powerdown_reset_ctrl_tb;
    logic clk, sys_rst, pd_enable, want_a, want_b, fuse_blown, rd_pattern, rd_signature;
    logic powerdown_pin_a, powerdown_pin_b, core_in_a_valid, core_in_b_valid;
    logic powered_down, core_ready, pattern_rd_denied;
    logic [7:0] want_pins, pin_in, core_out, core_oe_n, out_polarity, core_in, pin_out, pin_oe_n;
    logic [7:0] hold_out, hold_oe, hold_in;
    logic [15:0] pattern_word, signature_word, pattern_rd_data, signature_rd_data;
    logic [16:0] e;
    int err_total, n_checks;

    cprc_board u_board (.clk(clk), .core_ready(core_ready), .want_a(want_a), .want_b(want_b),
        .want_pins(want_pins), .powerdown_pin_a(powerdown_pin_a), .powerdown_pin_b(powerdown_pin_b),
        .pin_in(pin_in));
    cprc_ctrl dut (.clk(clk), .sys_rst(sys_rst), .pd_enable(pd_enable), .powerdown_pin_a(powerdown_pin_a),
        .powerdown_pin_b(powerdown_pin_b), .pin_in(pin_in), .core_out(core_out), .core_oe_n(core_oe_n),
        .out_polarity(out_polarity), .fuse_blown(fuse_blown), .rd_pattern(rd_pattern),
        .rd_signature(rd_signature), .pattern_word(pattern_word), .signature_word(signature_word),
        .core_in(core_in), .core_in_a_valid(core_in_a_valid), .core_in_b_valid(core_in_b_valid),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .powered_down(powered_down), .core_ready(core_ready),
        .pattern_rd_data(pattern_rd_data), .pattern_rd_denied(pattern_rd_denied),
        .signature_rd_data(signature_rd_data));

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    // bounded wait on core_ready (rdy set) or powered_down
    task automatic wait_lvl(input bit rdy, input logic v);
        int i;
        i = 0;
        while (((rdy ? core_ready : powered_down) !== v) && i < 20) begin
            @(negedge clk);
            i++;
        end
        chk(rdy ? "core_ready" : "powered_down", 16'(rdy ? core_ready : powered_down), 16'(v));
    endtask : wait_lvl

    // pattern is hidden behind a blown fuse, flagged as denied
    function automatic logic [16:0] exp_pat(input logic fuse, input logic [15:0] w);
        return fuse ? 17'h10000 : {1'b0, w};
    endfunction : exp_pat

    task automatic pd_run(input logic a, input logic b);
        core_out = 8'($urandom);
        core_oe_n = 8'($urandom);
        want_pins = 8'($urandom);
        cyc(8);
        chk("pin_out", 16'(pin_out), 16'(core_out));
        chk("pin_oe_n", 16'(pin_oe_n), 16'(core_oe_n));
        chk("core_in", 16'(core_in), 16'(want_pins));
        hold_out = pin_out;
        hold_oe = pin_oe_n;
        hold_in = core_in;
        want_a = a;
        want_b = b;
        wait_lvl(1'b0, 1'b1);
        // ready drops one cycle after the hold flag rises
        cyc(1);
        chk("core_ready", 16'(core_ready), 16'h0000);
        // inputs flip while frozen; none may leak through
        core_out = ~core_out;
        core_oe_n = ~core_oe_n;
        want_pins = ~want_pins;
        cyc(12);
        chk("pin_out", 16'(pin_out), 16'(hold_out));
        chk("pin_oe_n", 16'(pin_oe_n), 16'(hold_oe));
        chk("core_in", 16'(core_in), 16'(hold_in));
        want_a = 1'b0;
        want_b = 1'b0;
        wait_lvl(1'b0, 1'b0);
        wait_lvl(1'b1, 1'b1);
        cyc(8);
        chk("core_in", 16'(core_in), 16'(want_pins));
        chk("pin_out", 16'(pin_out), 16'(core_out));
    endtask : pd_run

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // generous bound: the sequence needs well under 1000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        conclude();
    end

    initial begin
        err_total = 0;
        n_checks = 0;
        void'($urandom(32'hC425));
        sys_rst = 1'b1;
        pd_enable = 1'b1;
        {want_a, want_b, fuse_blown, rd_pattern, rd_signature} = 5'h00;
        {want_pins, core_out, core_oe_n} = 24'h000000;
        {pattern_word, signature_word} = 32'h00000000;
        out_polarity = 8'($urandom);
        repeat (2) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        cyc(2);
        // ready must stay low for the whole settling count, no more
        for (int i = 0; i < `CPRC_SETTLE_CYC - 2; i++) begin
            chk("pin_out", 16'(pin_out), 16'(out_polarity));
            chk("pin_oe_n", 16'(pin_oe_n), 16'h0000);
            chk("core_ready", 16'(core_ready), 16'h0000);
            cyc(1);
        end
        chk("core_ready", 16'(core_ready), 16'h0001);
        chk("a_valid", 16'(core_in_a_valid), 16'h0000);
        chk("b_valid", 16'(core_in_b_valid), 16'h0000);
        pd_enable = 1'b0;
        cyc(2);
        chk("a_valid", 16'(core_in_a_valid), 16'h0001);
        chk("b_valid", 16'(core_in_b_valid), 16'h0001);
        want_a = 1'b1;
        want_b = 1'b1;
        cyc(12);
        chk("powered_down", 16'(powered_down), 16'h0000);
        want_a = 1'b0;
        want_b = 1'b0;
        // let the synced pins fall before power-down is armed again
        cyc(8);
        pd_enable = 1'b1;
        cyc(2);
        chk("a_valid", 16'(core_in_a_valid), 16'h0000);
        chk("powered_down", 16'(powered_down), 16'h0000);
        pd_run(1'b1, 1'b0);
        pd_run(1'b0, 1'b1);
        pd_run(1'b1, 1'b1);
        // strobes stay high: every cycle is a fresh read
        for (int k = 0; k < 6; k++) begin
            fuse_blown = k[0];
            pattern_word = 16'($urandom);
            signature_word = 16'($urandom);
            rd_pattern = 1'b1;
            rd_signature = 1'b1;
            cyc(1);
            e = exp_pat(fuse_blown, pattern_word);
            chk("pattern_data", pattern_rd_data, e[15:0]);
            chk("denied", 16'(pattern_rd_denied), 16'(e[16]));
            chk("signature", signature_rd_data, signature_word);
        end
        rd_pattern = 1'b0;
        rd_signature = 1'b0;
        cyc(1);
        chk("denied", 16'(pattern_rd_denied), 16'h0000);
        chk("signature", signature_rd_data, signature_word);
        sys_rst = 1'b1;
        cyc(2);
        sys_rst = 1'b0;
        cyc(3);
        chk("pin_out", 16'(pin_out), 16'(out_polarity));
        wait_lvl(1'b1, 1'b1);
        conclude();
    end
endmodule : cpld_powerdown_reset_ctrl_tb
